// ===== dts_seq.sv
// Purpose: Voltmeter trigger, inter-reading wait and reading storage sequencer
// Assumes: All inputs synchronous to i_clk_sys; APB slave with one access cycle
// Notes:   Converter handshake is o_meas_start pulse, i_meas_done pulse with value
// Operation
// - ASCII storage holds 60 readings parallel, 50 serial.
// - Packed BCD storage holds 100 readings parallel, 85 serial.
// - Storage starts off after reset; readings go straight to host.
// - With storage on, each reading of each trigger goes into the buffer until it holds its capacity; later ones are dropped.
// - Storage-read shows oldest reading; each clear-entry press shows the next.
// - Clear-entry on the last stored reading leaves the display unchanged.
// - Stored readings go to the host oldest first.
// - Output format is format alone when storage off, storage mode plus format otherwise.
// - Storage-read stops further buffer writes.
// - Four trigger modes coded 1 to 4; internal after reset.
// - Internal mode retriggers as soon as a burst finishes.
// - External pulse of at least 50 ns starts one burst, then idle.
// - External pulses during a measurement are ignored.
// - Software trigger fires exactly one burst.
// - Hold mode measures nothing until software trigger or mode change.
// - Measuring indicator is high while triggered and measuring.
// - Serial internal mode: next trigger waits for host to take the reading with pacing, continuous without.
// - Wait count 0 to 999999 in 100 us steps, after trigger and between readings.
// - Wait starts when a reading completes; next reading starts after it.
// - Readings per trigger 1 to 999, applied in every trigger mode.
// - Wait count is zero after reset.
module dts_seq
  import dts_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic      [31:0]      o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  input  wire logic             i_serial_variant,
  input  wire logic             i_external_trigger_in_n,
  input  wire logic             i_clear_entry_key,
  output logic                  o_meas_start,
  input  wire logic             i_meas_done,
  input  wire logic [RDG_W-1:0] i_meas_value,
  output logic                  o_measuring,
  output dts_rdg_s              o_out,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [RDG_W-1:0] o_display
);

  // Buffer capacity for a storage mode and variant
  function automatic logic [6:0] cap_of(input logic [1:0] mode, input logic ser);
    logic [6:0] c;
    c = 7'h00;
    if (mode == STORE_ASCII) begin
      c = ser ? CAP_ASCII_SER : CAP_ASCII_PAR;
    end else if (mode == STORE_PACKED_BCD) begin
      c = ser ? CAP_BCD_SER : CAP_BCD_PAR;
    end
    return c;
  endfunction

  // Register and sequencer state
  dts_state_e       state_q;
  logic [2:0]       trig_q;
  logic [1:0]       store_q;
  logic             pace_q;
  logic [1:0]       fmt_q;
  logic [9:0]       rpt_q;
  logic [19:0]      wait_q;
  logic [9:0]       remain_q;
  logic [10:0]      tick_q;
  logic [19:0]      wcnt_q;
  logic             ext_q;
  logic [RDG_W-1:0] hold_q;
  logic [6:0]       count_q;
  logic [6:0]       xfer_q;
  logic [6:0]       disp_q;
  logic             drain_q;
  logic [RDG_W-1:0] mem [0:BUF_DEPTH-1];

  // APB decode
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr    = i_psel & i_penable & o_pready & i_pwrite;
  wire hit_ctrl  = (i_paddr == REG_CTRL);
  wire hit_rpt   = (i_paddr == REG_RPT);
  wire hit_wait  = (i_paddr == REG_WAIT);
  wire hit_cmd   = (i_paddr == REG_CMD);
  wire hit_stat  = (i_paddr == REG_STATUS);
  wire hit_disp  = (i_paddr == REG_DISPLAY);
  wire mapped    = hit_ctrl | hit_rpt | hit_wait | hit_cmd | hit_stat | hit_disp;

  // Write fields and command strobes
  wire [2:0]  w_trig   = i_pwdata[CTRL_TRIG_LSB +: 3];
  wire [1:0]  w_store  = i_pwdata[CTRL_STORE_LSB +: 2];
  wire [9:0]  w_rpt    = i_pwdata[9:0];
  wire [19:0] w_wait   = i_pwdata[19:0];
  wire        wr_ctrl  = apb_wr & hit_ctrl;
  wire        wr_rpt   = apb_wr & hit_rpt & (w_rpt != 10'h000) & (w_rpt <= RPT_MAX);
  wire        wr_wait  = apb_wr & hit_wait & (w_wait <= WAIT_MAX);
  wire        sw_trig  = apb_wr & hit_cmd & i_pwdata[CMD_SWTRIG_BIT];
  wire        sread    = apb_wr & hit_cmd & i_pwdata[CMD_SREAD_BIT];
  wire        arm      = apb_wr & hit_cmd & i_pwdata[CMD_ARM_BIT];
  wire        trig_ok  = (w_trig >= TRIG_INTERNAL) & (w_trig <= TRIG_HOLD);
  wire        store_ok = (w_store <= STORE_PACKED_BCD);

  // Read data mux
  logic [31:0] rd_w;
  always_comb begin
    rd_w = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_w[CTRL_TRIG_LSB +: 3]  = trig_q;
      rd_w[CTRL_STORE_LSB +: 2] = store_q;
      rd_w[CTRL_PACE_BIT]       = pace_q;
      rd_w[CTRL_FMT_LSB +: 2]   = fmt_q;
    end else if (hit_rpt) begin
      rd_w[9:0] = rpt_q;
    end else if (hit_wait) begin
      rd_w[19:0] = wait_q;
    end else if (hit_stat) begin
      rd_w[STAT_BUSY_BIT]      = o_measuring;
      rd_w[STAT_DRAIN_BIT]     = drain_q;
      rd_w[STAT_CNT_LSB +: 7]  = count_q;
      rd_w[STAT_PTR_LSB +: 7]  = disp_q;
    end else if (hit_disp) begin
      rd_w[RDG_W-1:0] = o_display;
    end
  end

  // APB answer registered in the setup cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup & ~mapped;
      o_prdata  <= (apb_setup & ~i_pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // Control register; illegal codes are ignored
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      trig_q  <= TRIG_RST;
      store_q <= STORE_RST;
      pace_q  <= 1'b0;
      fmt_q   <= FMT_RST;
    end else if (wr_ctrl) begin
      if (trig_ok) begin
        trig_q <= w_trig;
      end
      if (store_ok) begin
        store_q <= w_store;
      end
      pace_q <= i_pwdata[CTRL_PACE_BIT];
      fmt_q  <= i_pwdata[CTRL_FMT_LSB +: 2];
    end
  end

  // Readings per trigger and wait count
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rpt_q  <= RPT_RST;
      wait_q <= WAIT_RST;
    end else begin
      if (wr_rpt) begin
        rpt_q <= w_rpt;
      end
      if (wr_wait) begin
        wait_q <= w_wait;
      end
    end
  end

  // External trigger falling edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_q <= 1'b1;
    end else begin
      ext_q <= i_external_trigger_in_n;
    end
  end

  // Trigger sources, accepted only while idle
  wire is_idle   = (state_q == SQ_IDLE);
  wire ext_fall  = ext_q & ~i_external_trigger_in_n;
  wire mode_int  = (trig_q == TRIG_INTERNAL);
  wire pace_hold = i_serial_variant & mode_int & pace_q & o_out_valid;
  wire cont_out  = i_serial_variant & mode_int & ~pace_q;
  wire auto_trig = mode_int & ~pace_hold;
  wire external_trigger_in  = (trig_q == TRIG_EXTERNAL) & ext_fall;
  wire trig_go   = is_idle & (sw_trig | external_trigger_in | auto_trig);
  wire wait_done = (wcnt_q >= wait_q);
  wire wait_zero = (wait_q == 20'h00000);

  // Delivery of a finished reading
  wire slot_free  = ~o_out_valid | i_out_ready;
  wire store_on   = (store_q != STORAGE_OFF);
  wire in_send    = (state_q == SQ_SEND);
  wire send_ok    = store_on | slot_free | cont_out;
  wire sent       = in_send & send_ok;
  wire last_rdg   = (remain_q == 10'h001);
  wire [6:0] cap  = cap_of(store_q, i_serial_variant);
  wire buf_wr     = sent & store_on & ~drain_q & (count_q < cap);
  wire direct_snd = sent & ~store_on;
  wire drain_snd  = drain_q & slot_free & (xfer_q < count_q) & ~direct_snd;
  wire go_meas    = (trig_go & wait_zero)
                  | ((state_q == SQ_WAIT) & wait_done & ~wr_wait)
                  | (sent & ~last_rdg & wait_zero);

  // Sequencer state
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= SQ_IDLE;
    end else begin
      case (state_q)
        SQ_IDLE: begin
          if (trig_go) begin
            state_q <= wait_zero ? SQ_MEAS : SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (go_meas) begin
            state_q <= SQ_MEAS;
          end
        end
        SQ_MEAS: begin
          if (i_meas_done) begin
            state_q <= SQ_SEND;
          end
        end
        default: begin
          if (sent) begin
            if (last_rdg) begin
              state_q <= SQ_IDLE;
            end else begin
              state_q <= wait_zero ? SQ_MEAS : SQ_WAIT;
            end
          end
        end
      endcase
    end
  end

  // Burst counter and indicator
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      remain_q    <= 10'h000;
      o_measuring <= 1'b0;
    end else if (trig_go) begin
      remain_q    <= rpt_q;
      o_measuring <= 1'b1;
    end else if (sent) begin
      remain_q    <= remain_q - 10'h001;
      o_measuring <= ~last_rdg;
    end
  end

  // Wait prescaler and step counter
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_q <= 11'h000;
      wcnt_q <= 20'h00000;
    end else if (wr_wait | (state_q != SQ_WAIT)) begin
      tick_q <= 11'h000;
      wcnt_q <= 20'h00000;
    end else if (tick_q == TICK_LAST) begin
      tick_q <= 11'h000;
      wcnt_q <= wcnt_q + 20'h00001;
    end else begin
      tick_q <= tick_q + 11'h001;
    end
  end

  // Converter start pulse and reading capture
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_meas_start <= 1'b0;
      hold_q       <= '0;
    end else begin
      o_meas_start <= go_meas;
      if ((state_q == SQ_MEAS) & i_meas_done) begin
        hold_q <= i_meas_value;
      end
    end
  end

  // Reading buffer
  always_ff @(posedge i_clk_sys) begin
    if (buf_wr) begin
      mem[count_q] <= hold_q;
    end
  end

  // Fill count, drain flag and transfer pointer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_q <= 7'h00;
      drain_q <= 1'b0;
      xfer_q  <= 7'h00;
    end else if (arm) begin
      count_q <= 7'h00;
      drain_q <= 1'b0;
      xfer_q  <= 7'h00;
    end else if (sread) begin
      drain_q <= 1'b1;
      xfer_q  <= 7'h00;
    end else begin
      if (buf_wr) begin
        count_q <= count_q + 7'h01;
      end
      if (drain_snd) begin
        xfer_q <= xfer_q + 7'h01;
      end
    end
  end

  // Front panel display of stored readings
  wire       has_next = (disp_q + 7'h01) < count_q;
  wire [6:0] nxt_ptr  = disp_q + 7'h01;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      disp_q    <= 7'h00;
      o_display <= '0;
    end else if (arm) begin
      disp_q    <= 7'h00;
      o_display <= '0;
    end else if (sread) begin
      disp_q    <= 7'h00;
      o_display <= (count_q != 7'h00) ? mem[0] : '0;
    end else if (i_clear_entry_key & drain_q & has_next) begin
      disp_q    <= nxt_ptr;
      o_display <= mem[nxt_ptr];
    end
  end

  // Host output word
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_out_valid <= 1'b0;
      o_out       <= '0;
    end else if (direct_snd) begin
      o_out_valid      <= 1'b1;
      o_out.value      <= hold_q;
      o_out.store_mode <= STORAGE_OFF;
      o_out.out_fmt    <= fmt_q;
    end else if (drain_snd) begin
      o_out_valid      <= 1'b1;
      o_out.value      <= mem[xfer_q];
      o_out.store_mode <= store_q;
      o_out.out_fmt    <= fmt_q;
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_wait_to_meas;
    (state_q == SQ_WAIT) ##1 (state_q == SQ_MEAS);
  endsequence

  sequence s_burst_last;
    in_send && send_ok && last_rdg;
  endsequence

  ext_busy_ignore_a: assert property ((state_q != SQ_IDLE) && ext_fall && !sent
    |=> remain_q == $past(remain_q))
    else $error("external pulse restarted a running burst");
  buf_full_drop_a: assert property ((count_q >= cap) |=> count_q <= $past(count_q) || $past(arm))
    else $error("full buffer still written");
  drain_no_fill_a: assert property (drain_q && !arm |=> count_q == $past(count_q))
    else $error("buffer filled while draining");
  meas_indicator_a: assert property (o_measuring == (state_q != SQ_IDLE))
    else $error("measuring indicator out of step");
  hold_no_meas_a: assert property (is_idle && (trig_q == TRIG_HOLD) && !sw_trig
    |=> state_q == SQ_IDLE)
    else $error("measurement started in hold mode");
  int_retrig_a: assert property (is_idle && mode_int && !pace_hold |=> !is_idle)
    else $error("internal mode did not retrigger");
  wait_expired_a: assert property (s_wait_to_meas |-> $past(wcnt_q) >= $past(wait_q))
    else $error("reading started before wait expired");
  burst_end_a: assert property (s_burst_last |=> is_idle && !o_measuring && !o_meas_start)
    else $error("burst did not end after last reading");
  burst_load_a: assert property (trig_go |=> remain_q == $past(rpt_q) && o_measuring)
    else $error("burst length not taken from count");
  disp_last_a: assert property (i_clear_entry_key && !has_next && !sread && !arm
    |=> $stable(o_display) && $stable(disp_q))
    else $error("display moved past last reading");
  drain_order_a: assert property (drain_snd && !arm && !sread |=> o_out_valid && xfer_q == $past(xfer_q) + 7'h01)
    else $error("stored readings not sent in order");
  start_pulse_a: assert property (o_meas_start |=> !o_meas_start && state_q == SQ_MEAS)
    else $error("start pulse longer than one cycle");

endmodule

// ===== dts_pkg.sv
// Purpose: Shared constants and types for the voltmeter trigger/storage sequencer
// Assumes: 20 MHz system clock, APB register access
// Notes:   Codes of trigger and storage modes match the command numbers
package dts_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_RPT     = 8'h04;
  localparam logic [7:0] REG_WAIT    = 8'h08;
  localparam logic [7:0] REG_CMD     = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_DISPLAY = 8'h14;
  // Field positions
  localparam int CTRL_TRIG_LSB  = 0;
  localparam int CTRL_STORE_LSB = 4;
  localparam int CTRL_PACE_BIT  = 6;
  localparam int CTRL_FMT_LSB   = 8;
  localparam int CMD_SWTRIG_BIT = 0;
  localparam int CMD_SREAD_BIT  = 1;
  localparam int CMD_ARM_BIT    = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DRAIN_BIT = 1;
  localparam int STAT_CNT_LSB   = 8;
  localparam int STAT_PTR_LSB   = 16;
  // Mode codes
  localparam logic [2:0] TRIG_INTERNAL    = 3'h1;
  localparam logic [2:0] TRIG_EXTERNAL    = 3'h2;
  localparam logic [2:0] TRIG_SOFTWARE    = 3'h3;
  localparam logic [2:0] TRIG_HOLD        = 3'h4;
  localparam logic [1:0] STORAGE_OFF      = 2'h0;
  localparam logic [1:0] STORE_ASCII      = 2'h1;
  localparam logic [1:0] STORE_PACKED_BCD = 2'h2;
  // Buffer capacities: 60/50 ASCII, 100/85 packed BCD
  localparam int         BUF_DEPTH     = 100;
  localparam logic [6:0] CAP_ASCII_PAR = 7'h3C;
  localparam logic [6:0] CAP_ASCII_SER = 7'h32;
  localparam logic [6:0] CAP_BCD_PAR   = 7'h64;
  localparam logic [6:0] CAP_BCD_SER   = 7'h55;
  // Limits and reset values
  localparam logic [9:0]  RPT_MAX   = 10'h3E7;
  localparam logic [19:0] WAIT_MAX  = 20'hF423F;
  localparam logic [2:0]  TRIG_RST  = TRIG_INTERNAL;
  localparam logic [1:0]  STORE_RST = STORAGE_OFF;
  localparam logic [9:0]  RPT_RST   = 10'h001;
  localparam logic [19:0] WAIT_RST  = 20'h00000;
  localparam logic [1:0]  FMT_RST   = 2'h1;
  // Timing
  localparam int          CLK_HZ        = 20000000;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          WAIT_STEP_US  = 100;
  localparam int          TICK_CYC      = WAIT_STEP_US * (CLK_HZ / 1000000);
  localparam logic [10:0] TICK_LAST     = 11'(TICK_CYC - 1);
  localparam int          EXT_PULSE_NS  = 50;
  localparam int          EXT_PULSE_CYC = (EXT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RDG_W         = 24;
  // Sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_MEAS, SQ_SEND} dts_state_e;
  // Reading as handed to the host
  typedef struct packed {
    logic [1:0]       store_mode;
    logic [1:0]       out_fmt;
    logic [RDG_W-1:0] value;
  } dts_rdg_s;
endpackage

// ===== dts_conv_model.sv
// Purpose: Converter model that answers start pulses with readings
// Assumes: One conversion at a time; delay chosen per start by the bench
// Notes:   While no result is offered the value line shows the inverted last result
module dts_conv_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [2:0]  i_delay,
  output logic             o_done,
  output logic [23:0]      o_value,
  output logic [23:0]      o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  left_q;
  logic        busy_q;
  logic [23:0] res_q;

  // Count down the conversion time, then offer one numbered result
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      left_q  <= 4'h0;
      busy_q  <= 1'b0;
      o_done  <= 1'b0;
      o_count <= 24'h000000;
      res_q   <= 24'h000000;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_q <= 1'b1;
        left_q <= {1'b0, i_delay};
      end else if (busy_q && left_q == 4'h0) begin
        busy_q  <= 1'b0;
        o_done  <= 1'b1;
        res_q   <= o_count;
        o_count <= o_count + 24'h000001;
      end else if (busy_q) begin
        left_q <= left_q - 4'h1;
      end
    end
  end

  // Stale value never repeats the last result
  assign o_value = o_done ? res_q : ~res_q;
endmodule

// ===== dts_seq_tb.sv
// Purpose: Self-checking bench for the trigger and storage sequencer
// Assumes: APB master with bounded waits; converter model on the far side
// Notes:   Expected readings are queued by the driver and checked as the host takes them
module dts_seq_tb
  import dts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, penable, pwrite, serial, ext_n, key;
  logic        start, done, measuring, out_valid, out_ready, pready, pslverr;
  logic        chk_en, gap_chk, rnd_rdy, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd, rd_q;
  logic [2:0]  delay;
  logic [23:0] value, count, display, b;
  logic [1:0]  sm;
  dts_rdg_s    out;
  dts_rdg_s    expq[$];
  int          fails, samples_checked, n_free, n_starts, since, s0;
  logic [6:0]  caps [4] = '{CAP_ASCII_PAR, CAP_ASCII_SER, CAP_BCD_PAR, CAP_BCD_SER};

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dts_seq uut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_variant(serial), .i_external_trigger_in_n(ext_n), .i_clear_entry_key(key), .o_meas_start(start),
    .i_meas_done(done), .i_meas_value(value), .o_measuring(measuring), .o_out(out),
    .o_out_valid(out_valid), .i_out_ready(out_ready), .o_display(display));

  dts_conv_model conv (.i_clk_sys(clk), .i_rst(rst), .i_start(start), .i_delay(delay),
    .o_done(done), .o_value(value), .o_count(count));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic err(input string m);
    fails++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) err(m);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Random host stalls and converter delays
  always @(posedge clk) begin
    rnd       <= xs(rnd);
    delay     <= rnd[4:2];
    out_ready <= rnd_rdy & (rnd[0] | rnd[1]);
  end

  // Output monitor: compare taken readings with the oldest note
  always @(posedge clk) begin
    if (start === 1'b1 && measuring !== 1'b1) err("start without indicator");
    if (start === 1'b1 && gap_chk && since < TICK_CYC) err("wait too short");
    since = (start === 1'b1) ? 0 : since + 1;
    n_starts += int'(start === 1'b1);
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (!chk_en) n_free++;
      else if (expq.size() == 0) err("unexpected reading");
      else begin
        samples_checked++;
        if (out !== expq.pop_front()) err("reading mismatch");
      end
    end
  end

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err("bus timeout");
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (err_q !== 1'b0) err("write refused");
  endtask

  // Wait for the burst to end and all notes to be taken
  task automatic wait_done;
    int k;
    k = 0;
    repeat (3) @(posedge clk);
    while ((measuring !== 1'b0 || expq.size() != 0) && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      err("idle timeout");
      stop_test();
    end
  endtask

  initial begin
    rnd = 32'h00000013;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {serial, key, ext_n, delay, out_ready} = {2'b00, 1'b1, 3'h0, 1'b0};
    {rnd_rdy, chk_en, gap_chk} = 3'b000;
    fails = 0;
    samples_checked = 0;
    n_free = 0;
    n_starts = 0;
    since = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Power-on settings and an unmapped address
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_q & 32'h37F, (32'(FMT_RST) << CTRL_FMT_LSB) | 32'(TRIG_RST), "ctrl reset");
    apb(1'b0, REG_RPT, 32'h0);
    chk(rd_q & 32'h3FF, 32'h1, "count reset");
    apb(1'b0, REG_WAIT, 32'h0);
    chk(rd_q & 32'hFFFFF, 32'h0, "wait reset");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err_q}, 32'h1, "unmapped accepted");
    // Refused values leave the settings alone
    wr(REG_RPT, 32'h0);
    wr(REG_WAIT, 32'hF4240);
    wr(REG_CTRL, 32'h100);
    apb(1'b0, REG_RPT, 32'h0);
    chk(rd_q & 32'h3FF, 32'h1, "zero count taken");
    apb(1'b0, REG_WAIT, 32'h0);
    chk(rd_q & 32'hFFFFF, 32'h0, "long wait taken");
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd_q & 32'h7, 32'(TRIG_RST), "bad trigger code taken");
    $display("reset test done");
    // Internal retrigger, then serial pacing on and off
    rnd_rdy <= 1'b1;
    s0 = n_free;
    repeat (300) @(posedge clk);
    chk(32'(n_free - s0 >= 3), 32'h1, "no retrigger");
    serial <= 1'b1;
    rnd_rdy <= 1'b0;
    wr(REG_CTRL, 32'h141);
    repeat (50) @(posedge clk);
    s0 = n_starts;
    repeat (300) @(posedge clk);
    chk(32'(n_starts - s0 <= 1), 32'h1, "paced retrigger");
    wr(REG_CTRL, 32'h101);
    s0 = n_starts;
    repeat (300) @(posedge clk);
    chk(32'(n_starts - s0 >= 3), 32'h1, "not continuous");
    serial <= 1'b0;
    rnd_rdy <= 1'b1;
    wr(REG_CTRL, 32'h104);
    wait_done();
    repeat (50) @(posedge clk);
    chk_en <= 1'b1;
    $display("internal test done");
    // Software burst of three with one wait step
    wr(REG_RPT, 32'h3);
    wr(REG_WAIT, 32'h1);
    wr(REG_CTRL, 32'h204);
    b = count;
    for (int i = 0; i < 3; i++) expq.push_back(dts_rdg_s'{STORAGE_OFF, 2'h2, 24'(b + i)});
    gap_chk <= 1'b1;
    wr(REG_CMD, 32'h1 << CMD_SWTRIG_BIT);
    wait_done();
    gap_chk <= 1'b0;
    $display("software test done");
    // External burst, second pulse lands mid-burst
    wr(REG_CTRL, 32'h202);
    wr(REG_RPT, 32'h2);
    b = count;
    for (int i = 0; i < 2; i++) expq.push_back(dts_rdg_s'{STORAGE_OFF, 2'h2, 24'(b + i)});
    for (int p = 0; p < 2; p++) begin
      ext_n <= 1'b0;
      repeat (EXT_PULSE_CYC) @(posedge clk);
      ext_n <= 1'b1;
      repeat (200) @(posedge clk);
    end
    wait_done();
    repeat (100) @(posedge clk);
    wr(REG_WAIT, 32'h0);
    $display("external test done");
    // Hold mode takes nothing
    wr(REG_CTRL, 32'h204);
    s0 = n_starts;
    repeat (500) @(posedge clk);
    chk(32'(n_starts), 32'(s0), "hold measured");
    $display("hold test done");
    // Fill each storage mode past its capacity
    for (int m = 0; m < 4; m++) begin
      sm = (m < 2) ? STORE_ASCII : STORE_PACKED_BCD;
      serial <= m[0];
      wr(REG_CMD, 32'h1 << CMD_ARM_BIT);
      wr(REG_CTRL, 32'h204 | (32'(sm) << CTRL_STORE_LSB));
      wr(REG_RPT, 32'(caps[m]) + 32'h3);
      b = count;
      wr(REG_CMD, 32'h1 << CMD_SWTRIG_BIT);
      wait_done();
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd_q & 32'h7F00, 32'(caps[m]) << STAT_CNT_LSB, "stored count");
    end
    $display("capacity test done");
    // Drain the last buffer to host and display
    for (int i = 0; i < 85; i++) expq.push_back(dts_rdg_s'{STORE_PACKED_BCD, 2'h2, 24'(b + i)});
    wr(REG_CMD, 32'h1 << CMD_SREAD_BIT);
    repeat (2) @(posedge clk);
    chk({8'h0, display}, {8'h0, b}, "first shown");
    wr(REG_RPT, 32'h1);
    wr(REG_CMD, 32'h1 << CMD_SWTRIG_BIT);
    for (int i = 1; i < 87; i++) begin
      key <= 1'b1;
      @(posedge clk);
      key <= 1'b0;
      repeat (2) @(posedge clk);
      chk({8'h0, display}, {8'h0, b + 24'((i < 84) ? i : 84)}, "display step");
    end
    // Display index and shown reading through the register bus
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd_q & 32'h007F0002, (32'h54 << STAT_PTR_LSB) | (32'h1 << STAT_DRAIN_BIT), "display index");
    apb(1'b0, REG_DISPLAY, 32'h0);
    chk(rd_q, {8'h0, b + 24'h54}, "display register");
    wait_done();
    wr(REG_CMD, 32'h1 << CMD_ARM_BIT);
    $display("drain test done");
    stop_test();
  end
endmodule
